// ===== hdl/ncs_pkg.sv
// Package of constants for node configuration and status indication
package ncs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SWITCH   = 8'h04;
  localparam logic [7:0] ADDR_DO       = 8'h08;
  localparam logic [7:0] ADDR_LEDSTAT  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_POWER_OK  = 0;
  localparam int CTRL_HEARTBEAT = 1;
  localparam int CTRL_ID_CONFL  = 2;
  localparam int CTRL_TX_FAIL   = 3;
  localparam int CTRL_BUS_OFF   = 4;
  localparam int CTRL_WIDTH     = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // ---------------------------------------------------------------
  // Interrupt status fields
  // ---------------------------------------------------------------
  localparam int IRQ_ID_CONFL = 0;
  localparam int IRQ_TX_FAIL  = 1;
  localparam int IRQ_BUS_OFF  = 2;
  localparam int IRQ_HB_LOST  = 3;
  localparam int IRQ_WIDTH    = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // ---------------------------------------------------------------
  // Switch decoding
  // ---------------------------------------------------------------
  localparam logic [6:0] NODE_ID_MAX    = 7'h63;
  localparam logic [6:0] NODE_ID_UPDATE = 7'h00;
  localparam int         PAIR_MODE_BIT  = 3;

  // ---------------------------------------------------------------
  // Flash timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int FLASH_ON_MS  = 200;
  localparam int FLASH_OFF_MS = 200;
  localparam int PAUSE_MS     = 1000;
  localparam int FLASH_ON_CYC  = CLK_MHZ * 1000 * FLASH_ON_MS;
  localparam int FLASH_OFF_CYC = CLK_MHZ * 1000 * FLASH_OFF_MS;
  localparam int PAUSE_CYC     = CLK_MHZ * 1000 * PAUSE_MS;

  typedef enum logic [1:0] {
    NCS_LED_DARK   = 2'b00,
    NCS_LED_SINGLE = 2'b01,
    NCS_LED_DOUBLE = 2'b11,
    NCS_LED_STEADY = 2'b10
  } ncs_led_mode_t;

  typedef enum logic [2:0] {
    NCS_FL_ON1   = 3'b000,
    NCS_FL_OFF1  = 3'b001,
    NCS_FL_ON2   = 3'b011,
    NCS_FL_PAUSE = 3'b010
  } ncs_flash_state_t;

endpackage

// ===== hdl/ncs_flasher.sv
// Free-running single and double flash pattern generator
`timescale 1ns/100ps
module ncs_flasher #(
  parameter int ON_CYC    = ncs_pkg::FLASH_ON_CYC,
  parameter int OFF_CYC   = ncs_pkg::FLASH_OFF_CYC,
  parameter int PAUSE_CYC = ncs_pkg::PAUSE_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  output logic      single_flash,
  output logic      double_flash
);

  ncs_pkg::ncs_flash_state_t state;
  ncs_pkg::ncs_flash_state_t next_state;
  logic [31:0]               count;
  logic [31:0]               limit;
  wire                       done = (count >= limit);

  always_comb
  begin
    next_state = state;
    limit      = 32'(ON_CYC - 1);
    unique case (state)
      ncs_pkg::NCS_FL_ON1:   next_state = ncs_pkg::NCS_FL_OFF1;
      ncs_pkg::NCS_FL_OFF1:
      begin
        limit      = 32'(OFF_CYC - 1);
        next_state = ncs_pkg::NCS_FL_ON2;
      end
      ncs_pkg::NCS_FL_ON2:   next_state = ncs_pkg::NCS_FL_PAUSE;
      ncs_pkg::NCS_FL_PAUSE:
      begin
        limit      = 32'(PAUSE_CYC - 1);
        next_state = ncs_pkg::NCS_FL_ON1;
      end
      default:
      begin
        limit      = 32'h0;
        next_state = ncs_pkg::NCS_FL_ON1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state        <= ncs_pkg::NCS_FL_ON1;
      count        <= 32'h0;
      single_flash <= 1'b0;
      double_flash <= 1'b0;
    end
    else
    begin
      count        <= done ? 32'h0 : count + 32'h1;
      state        <= done ? next_state : state;
      single_flash <= (state == ncs_pkg::NCS_FL_ON1);
      double_flash <= (state == ncs_pkg::NCS_FL_ON1) || (state == ncs_pkg::NCS_FL_ON2);
    end
  end

endmodule

// ===== hdl/ncs_switch_decode.sv
// Rotary switch decoder: node identifier, bit rate and mode
`timescale 1ns/100ps
module ncs_switch_decode (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] sw_tens,
  input  wire logic [3:0] sw_units,
  input  wire logic [3:0] sw_rate,
  output logic      [6:0] node_id,
  output logic            id_valid,
  output logic            fw_update,
  output logic      [2:0] rate_sel,
  output logic            pair_mode
);

  wire [6:0] next_node_id = {3'h0, sw_tens} * 7'd10 + {3'h0, sw_units};
  wire       digits_ok    = (sw_tens <= 4'h9) && (sw_units <= 4'h9);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      node_id   <= 7'h00;
      id_valid  <= 1'b0;
      fw_update <= 1'b0;
      rate_sel  <= 3'h0;
      pair_mode <= 1'b0;
    end
    else
    begin
      node_id   <= next_node_id;
      id_valid  <= digits_ok && (next_node_id <= ncs_pkg::NODE_ID_MAX)
                   && (next_node_id != ncs_pkg::NODE_ID_UPDATE);
      fw_update <= digits_ok && (next_node_id == ncs_pkg::NODE_ID_UPDATE);
      rate_sel  <= sw_rate[2:0];
      pair_mode <= sw_rate[ncs_pkg::PAIR_MODE_BIT];
    end
  end

endmodule

// ===== hdl/ncs_top.sv
// Node configuration, status LEDs and output channel logic
`timescale 1ns/100ps
module ncs_top #(
  parameter int DO_WIDTH  = 8,
  parameter int ON_CYC    = ncs_pkg::FLASH_ON_CYC,
  parameter int OFF_CYC   = ncs_pkg::FLASH_OFF_CYC,
  parameter int PAUSE_CYC = ncs_pkg::PAUSE_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic [3:0]          sw_tens,
  input  wire logic [3:0]          sw_units,
  input  wire logic [3:0]          sw_rate,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  output logic      [6:0]          node_id,
  output logic                     id_valid,
  output logic                     fw_update,
  output logic      [2:0]          rate_sel,
  output logic      [9:0]          rate_kbps,
  output logic                     pair_mode,
  output logic                     run_led,
  output logic                     err_led,
  output logic      [DO_WIDTH-1:0] do_pin,
  output logic      [DO_WIDTH-1:0] do_led,
  output logic                     irq
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [9:0] ncs_rate_kbps(input logic [2:0] sel);
    logic [9:0] r;
    r = 10'd10;
    unique case (sel)
      3'h0: r = 10'd10;
      3'h1: r = 10'd20;
      3'h2: r = 10'd50;
      3'h3: r = 10'd125;
      3'h4: r = 10'd250;
      3'h5: r = 10'd500;
      3'h6: r = 10'd800;
      3'h7: r = 10'd1000;
    endcase
    return r;
  endfunction

  function automatic logic ncs_led(input ncs_pkg::ncs_led_mode_t m,
                                   input logic s, input logic d);
    logic v;
    v = 1'b0;
    unique case (m)
      ncs_pkg::NCS_LED_DARK:   v = 1'b0;
      ncs_pkg::NCS_LED_SINGLE: v = s;
      ncs_pkg::NCS_LED_DOUBLE: v = d;
      ncs_pkg::NCS_LED_STEADY: v = 1'b1;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  logic single_flash;
  logic double_flash;
  logic [6:0] dec_node_id;
  logic       dec_id_valid;
  logic       dec_fw_update;
  logic [2:0] dec_rate_sel;
  logic       dec_pair_mode;

  ncs_switch_decode u_decode (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .sw_tens   (sw_tens),
    .sw_units  (sw_units),
    .sw_rate   (sw_rate),
    .node_id   (dec_node_id),
    .id_valid  (dec_id_valid),
    .fw_update (dec_fw_update),
    .rate_sel  (dec_rate_sel),
    .pair_mode (dec_pair_mode)
  );

  ncs_flasher #(
    .ON_CYC    (ON_CYC),
    .OFF_CYC   (OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_flasher (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .single_flash (single_flash),
    .double_flash (double_flash)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [ncs_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [DO_WIDTH-1:0]            do_state;
  logic [ncs_pkg::IRQ_WIDTH-1:0]  irq_stat;
  logic [ncs_pkg::IRQ_WIDTH-1:0]  irq_en;
  logic [ncs_pkg::CTRL_WIDTH-1:0] ctrl_d;

  wire wr_ctrl = reg_wr && (reg_addr == ncs_pkg::ADDR_CTRL);
  wire wr_do   = reg_wr && (reg_addr == ncs_pkg::ADDR_DO);
  wire wr_clr  = reg_wr && (reg_addr == ncs_pkg::ADDR_IRQ_CLR);
  wire wr_en   = reg_wr && (reg_addr == ncs_pkg::ADDR_IRQ_EN);

  wire power_ok  = ctrl[ncs_pkg::CTRL_POWER_OK];
  wire heartbeat = ctrl[ncs_pkg::CTRL_HEARTBEAT];
  wire id_confl  = ctrl[ncs_pkg::CTRL_ID_CONFL];
  wire tx_fail   = ctrl[ncs_pkg::CTRL_TX_FAIL];
  wire bus_off   = ctrl[ncs_pkg::CTRL_BUS_OFF];

  // Rising edges of fault bits, and a heartbeat drop while powered, raise events
  wire [ncs_pkg::IRQ_WIDTH-1:0] irq_event = {
    ctrl_d[ncs_pkg::CTRL_HEARTBEAT] & ~heartbeat & power_ok,
    bus_off & ~ctrl_d[ncs_pkg::CTRL_BUS_OFF],
    tx_fail & ~ctrl_d[ncs_pkg::CTRL_TX_FAIL],
    id_confl & ~ctrl_d[ncs_pkg::CTRL_ID_CONFL]
  };
  wire [ncs_pkg::IRQ_WIDTH-1:0] clr_mask = wr_clr ? reg_wdata[ncs_pkg::IRQ_WIDTH-1:0]
                                                  : '0;
  // Set wins over a clear in the same cycle
  wire [ncs_pkg::IRQ_WIDTH-1:0] next_irq_stat = (irq_stat & ~clr_mask) | irq_event;

  // ---------------------------------------------------------------
  // LED mode selection
  // ---------------------------------------------------------------
  ncs_pkg::ncs_led_mode_t run_mode;
  ncs_pkg::ncs_led_mode_t err_mode;

  assign run_mode = !power_ok  ? ncs_pkg::NCS_LED_DARK :
                    !heartbeat ? ncs_pkg::NCS_LED_SINGLE :
                                 ncs_pkg::NCS_LED_STEADY;

  assign err_mode = bus_off  ? ncs_pkg::NCS_LED_STEADY :
                    tx_fail  ? ncs_pkg::NCS_LED_DOUBLE :
                    id_confl ? ncs_pkg::NCS_LED_SINGLE :
                               ncs_pkg::NCS_LED_DARK;

  wire next_run_led = ncs_led(run_mode, single_flash, double_flash);
  wire next_err_led = ncs_led(err_mode, single_flash, double_flash);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [31:0] led_word = {27'h0, err_mode == ncs_pkg::NCS_LED_STEADY, err_mode,
                          run_mode == ncs_pkg::NCS_LED_STEADY, 1'b0};
  wire [31:0] sw_word  = {16'h0, 1'(dec_fw_update), 1'(dec_id_valid), dec_pair_mode,
                          dec_rate_sel, 3'h0, dec_node_id};
  wire [31:0] next_rdata =
    (reg_addr == ncs_pkg::ADDR_CTRL)     ? 32'(ctrl) :
    (reg_addr == ncs_pkg::ADDR_SWITCH)   ? sw_word :
    (reg_addr == ncs_pkg::ADDR_DO)       ? 32'(do_state) :
    (reg_addr == ncs_pkg::ADDR_LEDSTAT)  ? led_word :
    (reg_addr == ncs_pkg::ADDR_IRQ_STAT) ? 32'(irq_stat) :
    (reg_addr == ncs_pkg::ADDR_IRQ_EN)   ? 32'(irq_en) : 32'h0;

  // Control word and a delayed copy for edge detection
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl   <= ncs_pkg::CTRL_RESET;
      ctrl_d <= ncs_pkg::CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= reg_wdata[ncs_pkg::CTRL_WIDTH-1:0];
      ctrl_d <= ctrl;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      do_state <= '0;
    else if (wr_do)
      do_state <= reg_wdata[DO_WIDTH-1:0];
  end

  // Read data stands one cycle, then zero, so stale words never linger
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? next_rdata : 32'h0;
  end

  // ---------------------------------------------------------------
  // Interrupt registers
  // ---------------------------------------------------------------

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_en <= ncs_pkg::IRQ_RESET;
    else if (wr_en)
      irq_en <= reg_wdata[ncs_pkg::IRQ_WIDTH-1:0];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_stat <= ncs_pkg::IRQ_RESET;
    else
      irq_stat <= next_irq_stat;
  end

  // Built from the next status, so the level rises with the sticky bit
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(next_irq_stat & irq_en);
  end

  // ---------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------

  // Switch results get one more flop so each output leaves a register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      node_id   <= 7'h00;
      id_valid  <= 1'b0;
      fw_update <= 1'b0;
      rate_sel  <= 3'h0;
      rate_kbps <= 10'd10;
      pair_mode <= 1'b0;
    end
    else
    begin
      node_id   <= dec_node_id;
      id_valid  <= dec_id_valid;
      fw_update <= dec_fw_update;
      rate_sel  <= dec_rate_sel;
      rate_kbps <= ncs_rate_kbps(dec_rate_sel);
      pair_mode <= dec_pair_mode;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      run_led <= 1'b0;
      err_led <= 1'b0;
    end
    else
    begin
      run_led <= next_run_led;
      err_led <= next_err_led;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      do_pin <= '1;
      do_led <= '0;
    end
    else
    begin
      do_pin <= ~do_state;
      do_led <= do_state;
    end
  end

endmodule

// ===== sim/ncs_master_model.sv
// Behavioural network master supplying heartbeat and bus fault status
`timescale 1ns/100ps
module ncs_master_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       powered,
  input  wire logic       hb_alive,
  input  wire logic [1:0] fault,
  output logic      [4:0] ctrl_word
);
  // Fault code: 0 none, 1 id clash, 2 frames stuck, 3 bus off
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ctrl_word <= 5'h00;
    else
      ctrl_word <= {fault == 2'h3, fault == 2'h2, fault == 2'h1, hb_alive, powered};
  end
endmodule

// ===== sim/ncs_top_properties.sv
// Concurrent checks on the node configuration block ports
`timescale 1ns/100ps
module ncs_top_chk #(
  parameter int DO_WIDTH = 8
) (
  input logic                ref_clk,
  input logic                rst,
  input logic [3:0]          sw_tens,
  input logic [3:0]          sw_units,
  input logic [3:0]          sw_rate,
  input logic [7:0]          reg_addr,
  input logic [31:0]         reg_wdata,
  input logic                reg_wr,
  input logic                reg_rd,
  input logic [31:0]         reg_rdata,
  input logic [6:0]          node_id,
  input logic                fw_update,
  input logic [2:0]          rate_sel,
  input logic [9:0]          rate_kbps,
  input logic                pair_mode,
  input logic                run_led,
  input logic                err_led,
  input logic [DO_WIDTH-1:0] do_pin,
  input logic [DO_WIDTH-1:0] do_led
);
  localparam logic [9:0] KB [8] = '{10'h00a, 10'h014, 10'h032, 10'h07d,
                                    10'h0fa, 10'h1f4, 10'h320, 10'h3e8};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Switch decode
  // ---------------------------------------------------------------
  // Two flops plus the reset release edge, so four quiet edges
  sequence sw_steady;
    $stable({sw_tens, sw_units, sw_rate}) [*4];
  endsequence
  sequence ctrl_wr;
    reg_wr && reg_addr == ncs_pkg::ADDR_CTRL;
  endsequence
  chk_rate_mode: assert property (
    sw_steady |-> pair_mode == sw_rate[3] && rate_sel == sw_rate[2:0])
    else $error("rate mode decode off");
  chk_rate_table: assert property (
    sw_steady |-> rate_kbps == KB[sw_rate[2:0]])
    else $error("bit rate value off");
  chk_node_sum: assert property (
    sw_steady ##0 (sw_tens <= 4'h9 && sw_units <= 4'h9)
    |-> node_id == {3'h0, sw_tens} * 7'h0a + {3'h0, sw_units})
    else $error("node id sum off");
  chk_update_id: assert property (
    sw_steady |-> fw_update == (sw_tens == 4'h0 && sw_units == 4'h0))
    else $error("update select off");
  // ---------------------------------------------------------------
  // Output channels and LEDs
  // ---------------------------------------------------------------
  chk_pin_polarity: assert property (
    do_pin == ~do_led)
    else $error("channel pin not inverted");
  chk_do_readback: assert property (
    reg_rd && reg_addr == ncs_pkg::ADDR_DO |=> reg_rdata == 32'(do_led))
    else $error("channel readback off");
  chk_busoff_steady: assert property (
    ctrl_wr ##0 reg_wdata[ncs_pkg::CTRL_BUS_OFF] |-> ##3 err_led [*4])
    else $error("error led not steady");
  chk_err_dark: assert property (
    ctrl_wr ##0 reg_wdata[4:2] == 3'h0 |-> ##3 !err_led [*4])
    else $error("error led lit without fault");
  chk_run_dark: assert property (
    ctrl_wr ##0 !reg_wdata[ncs_pkg::CTRL_POWER_OK] |-> ##3 !run_led [*4])
    else $error("run led lit while down");
endmodule

bind ncs_top ncs_top_chk #(.DO_WIDTH(DO_WIDTH)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .sw_tens(sw_tens), .sw_units(sw_units),
  .sw_rate(sw_rate), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .node_id(node_id), .fw_update(fw_update),
  .rate_sel(rate_sel), .rate_kbps(rate_kbps), .pair_mode(pair_mode),
  .run_led(run_led), .err_led(err_led), .do_pin(do_pin), .do_led(do_led)
);

// ===== sim/tb_ncs_top.sv
// Self-checking bench for the node configuration and status block
`timescale 1ns/100ps
module tb_ncs_top;
  localparam logic [9:0] KB [8] = '{10'h00a, 10'h014, 10'h032, 10'h07d,
                                    10'h0fa, 10'h1f4, 10'h320, 10'h3e8};
  localparam logic [3:0] TN [5] = '{4'h3, 4'h9, 4'h0, 4'h0, 4'ha};
  localparam logic [3:0] UN [5] = '{4'h2, 4'h9, 4'h0, 4'h1, 4'h0};
  // Status case table: fault, run and error lit counts, LED status word
  localparam logic [1:0] FT [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  localparam int         RC [5] = '{0, 8, 40, 40, 40};
  localparam int         EC [5] = '{0, 8, 16, 40, 0};
  localparam logic [4:0] LS [5] = '{5'h00, 5'h04, 5'h0e, 5'h1a, 5'h02};
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  sw_tens   = 4'h0;
  logic [3:0]  sw_units  = 4'h0;
  logic [3:0]  sw_rate   = 4'h0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        powered   = 1'b0;
  logic        hb_alive  = 1'b0;
  logic [1:0]  fault     = 2'h0;
  logic [4:0]  ctrl_word;
  logic [31:0] reg_rdata;
  logic [6:0]  node_id;
  logic [2:0]  rate_sel;
  logic [9:0]  rate_kbps;
  logic [7:0]  do_pin;
  logic [7:0]  do_led;
  logic        id_valid, fw_update, pair_mode, run_led, err_led, irq;
  int          mismatches = 0;
  int          n_tests    = 0;

  always #2 ref_clk = ~ref_clk;

  ncs_master_model u_master (.ref_clk(ref_clk), .rst(rst), .powered(powered),
    .hb_alive(hb_alive), .fault(fault), .ctrl_word(ctrl_word));

  // Short flash intervals keep the pattern counts quick
  ncs_top #(.DO_WIDTH(8), .ON_CYC(4), .OFF_CYC(4), .PAUSE_CYC(8)) DUT (
    .ref_clk(ref_clk), .rst(rst), .sw_tens(sw_tens), .sw_units(sw_units),
    .sw_rate(sw_rate), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .node_id(node_id), .id_valid(id_valid),
    .fw_update(fw_update), .rate_sel(rate_sel), .rate_kbps(rate_kbps),
    .pair_mode(pair_mode), .run_led(run_led), .err_led(err_led), .do_pin(do_pin),
    .do_led(do_led), .irq(irq));

  // Rate switch is left at F by the sweep, so pair mode and rate 7 stand
  function automatic logic [31:0] exp_switch(input logic [3:0] t, input logic [3:0] u);
    return {16'h0, (t | u) == 4'h0, (t | u) != 4'h0, 4'hf, 3'h0, 7'(t * 7'd10 + u)};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask

  // Master status lands one edge later, then goes into the control word
  task automatic apply(input logic p, input logic h, input logic [1:0] f);
    @(posedge ref_clk);
    powered  <= p;
    hb_alive <= h;
    fault    <= f;
    settle(2);
    wr(ncs_pkg::ADDR_CTRL, {27'h0, ctrl_word});
    settle(4);
  endtask

  // Forty cycles are two whole flash periods, so any phase gives one count
  task automatic count_led(input string what, input bit run, input int exp);
    int c;
    c = 0;
    repeat (40)
    begin
      @(posedge ref_clk);
      #1;
      c += ((run ? run_led : err_led) === 1'b1) ? 1 : 0;
    end
    chk(what, 32'(exp), 32'(c));
  endtask

  task automatic wait_irq(input logic exp);
    int i;
    for (i = 0; i < 8 && irq !== exp; i++)
      settle(1);
    chk("irq", {31'h0, exp}, {31'h0, irq});
    if (irq !== exp)
      print_verdict();
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd("ctrl reset", ncs_pkg::ADDR_CTRL, 32'h0);
    for (int r = 0; r < 16; r++)
    begin
      @(posedge ref_clk);
      sw_rate <= 4'(r);
      settle(4);
      chk("pair_mode", 32'(r / 8), {31'h0, pair_mode});
      chk("rate_sel", 32'(r % 8), {29'h0, rate_sel});
      chk("rate_kbps", {22'h0, KB[r % 8]}, {22'h0, rate_kbps});
    end
    for (int i = 0; i < 5; i++)
    begin
      @(posedge ref_clk);
      sw_tens  <= TN[i];
      sw_units <= UN[i];
      settle(4);
      if (TN[i] <= 4'h9)
      begin
        chk("node_id", 32'(TN[i] * 10 + UN[i]), {25'h0, node_id});
        rd("switch word", ncs_pkg::ADDR_SWITCH, exp_switch(TN[i], UN[i]));
      end
      chk("id_valid", 32'(TN[i] <= 4'h9 && (TN[i] | UN[i]) != 4'h0), 32'(id_valid));
      chk("fw_update", 32'(TN[i] == 4'h0 && UN[i] == 4'h0), 32'(fw_update));
    end
    $display("test switches done");
    foreach (KB[i])
    begin
      wr(ncs_pkg::ADDR_DO, 32'(KB[i][7:0]));
      settle(2);
      chk("do_pin", {24'h0, ~KB[i][7:0]}, 32'(do_pin));
      chk("do_led", 32'(KB[i][7:0]), 32'(do_led));
      rd("do readback", ncs_pkg::ADDR_DO, 32'(KB[i][7:0]));
    end
    $display("test channels done");
    for (int i = 0; i < 5; i++)
    begin
      apply(i != 0, i > 1, FT[i]);
      count_led("run_led", 1'b1, RC[i]);
      count_led("err_led", 1'b0, EC[i]);
      rd("led status", ncs_pkg::ADDR_LEDSTAT, 32'(LS[i]));
    end
    $display("test leds done");
    rd("irq status", ncs_pkg::ADDR_IRQ_STAT, 32'h7);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ncs_pkg::ADDR_IRQ_EN, 32'h1);
    wait_irq(1'b1);
    wr(ncs_pkg::ADDR_IRQ_CLR, 32'h1);
    wait_irq(1'b0);
    rd("irq after clear", ncs_pkg::ADDR_IRQ_STAT, 32'h6);
    wr(ncs_pkg::ADDR_IRQ_EN, 32'h8);
    apply(1'b1, 1'b0, 2'h0);
    wait_irq(1'b1);
    wr(ncs_pkg::ADDR_IRQ_CLR, 32'hf);
    wait_irq(1'b0);
    rd("irq all clear", ncs_pkg::ADDR_IRQ_STAT, 32'h0);
    rd("clear reg", ncs_pkg::ADDR_IRQ_CLR, 32'h0);
    rd("irq enable", ncs_pkg::ADDR_IRQ_EN, 32'h8);
    rd("unmapped", 8'h1c, 32'h0);
    $display("test interrupts done");
    print_verdict();
  end
endmodule
